/* File: rtl/pin_test_pkg.sv */
/*
 pin_test_pkg: constants for the pin test sequencer.
 assumes one 25 MHz clock that is the host bus clock itself.
*/
// Behaviour
// RL1: tester holds reset low, straps test, irq pattern
// RL2: test starts at reset rise with valid straps
// RL3: pattern advances one step per host clock
// RL4: steps float high low float low high float
// RL5: every output and bidirectional pad takes part
// RL6: inputs, usb, dot clock, analog left alone
// RL7: isa pads keep weak pull-ups during test
// RL8: nand mode routes chain to suspend output
// RL9: tester holds test and irq7 high, walks inputs
// RL10: float drops enable, high/low override value
package pin_test_pkg;
   // ======================================
   // sizes
   localparam int N_PADS = 16;
   localparam int N_NAND = 8;
   localparam int N_STEP = 7;
   localparam int N_STRAP = 5;
   // which pads carry an always-on weak pull-up
   localparam logic [N_PADS-1:0] PULL_MASK = 16'h00ff;
   // ======================================
   // strap patterns, bit 4 is irq7 down to bit 0 irq3
   localparam logic [N_STRAP-1:0] STRAP_IO = 5'h16;
   localparam int STRAP_IRQ7 = 4;
   // per-step enable and level, bit 0 is step 1
   localparam logic [N_STEP-1:0] STEP_OE = 7'h36;
   localparam logic [N_STEP-1:0] STEP_LVL = 7'h22;
   // ======================================
   // wishbone register map
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam int CTRL_IO_EN = 0;
   localparam int CTRL_NAND_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int STAT_NAND = 8;
   localparam int STAT_ARMED = 9;
   localparam int STAT_POR = 10;
   // ======================================
   // sequencer states
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_S1   = 8'h02,
      ST_S2   = 8'h04,
      ST_S3   = 8'h08,
      ST_S4   = 8'h10,
      ST_S5   = 8'h20,
      ST_S6   = 8'h40,
      ST_S7   = 8'h80
   } seq_state_t;
endpackage

/* File: rtl/sync_pair.sv */
/*
 sync_pair: two-flop synchroniser for pin levels.
 assumes inputs arrive from outside the clock domain.
*/
module sync_pair #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] dout_d;

   always_comb
   begin
      meta_d = din;
      dout_d = meta_q;
   end

   // no reset value: the pin level is all that matters
   always_ff @(posedge clk)
   begin
      meta_q <= meta_d;
      dout   <= dout_d;
   end
endmodule

/* File: rtl/pad_override.sv */
/*
 pad_override: per-pad mux between functional logic and the
 test pattern. assumes override controls come from flops.
*/
module pad_override
   import pin_test_pkg::*;
(
   input  wire logic [pin_test_pkg::N_PADS-1:0] func_out,
   input  wire logic [pin_test_pkg::N_PADS-1:0] func_oe,
   input  wire logic                            ovr_en,
   input  wire logic                            ovr_oe,
   input  wire logic                            ovr_lvl,
   output logic      [pin_test_pkg::N_PADS-1:0] pad_out,
   output logic      [pin_test_pkg::N_PADS-1:0] pad_oe
);
   // ======================================
   // one mux per pad
   genvar i;
   generate
      for (i = 0; i < N_PADS; i++)
      begin : g_pad
         // float drops the enable, high/low force the value [RL10] [RL5]
         assign pad_oe[i]  = ovr_en ? ovr_oe : func_oe[i];
         assign pad_out[i] = ovr_en ? ovr_lvl : func_out[i];
      end
   endgenerate
endmodule

/* File: rtl/io_pin_test_sequencer.sv */
/*
 io_pin_test_sequencer: strap decode, seven-step pad test and
 nand chain output, with a classic wishbone register slave.
 assumes clk is the host bus clock; straps and chain inputs
 are pins and are synchronised here.
*/
module io_pin_test_sequencer
   import pin_test_pkg::*;
(
   input  wire logic                             clk,
   input  wire logic                             srst,
   // pins
   input  wire logic                             por_n,
   input  wire logic                             test_pin,
   input  wire logic [pin_test_pkg::N_STRAP-1:0] irq_strap,
   input  wire logic [pin_test_pkg::N_NAND-1:0]  nand_in,
   input  wire logic                             dot_clock_src,
   output logic                                  dot_clock_out,
   // functional side
   input  wire logic [pin_test_pkg::N_PADS-1:0]  func_out,
   input  wire logic [pin_test_pkg::N_PADS-1:0]  func_oe,
   input  wire logic                             func_suspend_n,
   output logic      [pin_test_pkg::N_PADS-1:0]  pad_out,
   output logic      [pin_test_pkg::N_PADS-1:0]  pad_oe,
   output logic      [pin_test_pkg::N_PADS-1:0]  pad_pullup_en,
   output logic                                  suspend_request_out_n,
   output logic                                  suspend_oe,
   // wishbone slave
   input  wire logic                             wb_cyc_i,
   input  wire logic                             wb_stb_i,
   input  wire logic                             wb_we_i,
   input  wire logic [3:0]                       wb_adr_i,
   input  wire logic [3:0]                       wb_sel_i,
   input  wire logic [31:0]                      wb_dat_i,
   output logic      [31:0]                      wb_dat_o,
   output logic                                  wb_ack_o
);
   // ======================================
   // pin synchronisers
   logic [N_STRAP+1:0] pins_s;
   logic [N_NAND-1:0]  nand_s;
   logic               por_s;
   logic               test_s;
   logic [N_STRAP-1:0] strap_s;

   sync_pair #(.W(N_STRAP + 2)) u_sync_pins (
      .clk  (clk),
      .srst (srst),
      .din  ({por_n, test_pin, irq_strap}),
      .dout (pins_s)
   );

   sync_pair #(.W(N_NAND)) u_sync_nand (
      .clk  (clk),
      .srst (srst),
      .din  (nand_in),
      .dout (nand_s)
   );

   assign por_s   = pins_s[N_STRAP+1];
   assign test_s  = pins_s[N_STRAP];
   assign strap_s = pins_s[N_STRAP-1:0];

   // ======================================
   // registers
   logic [1:0] ctrl_q;
   logic [1:0] ctrl_d;
   logic       ack_q;
   logic       ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic       wb_req;

   // ======================================
   // strap capture and start detect
   logic       por_prev_q;
   logic       por_prev_d;
   logic       io_armed_q;
   logic       io_armed_d;
   logic       nand_q;
   logic       nand_d;
   logic       por_rise;
   logic       io_straps;
   logic       nand_straps;

   assign io_straps   = test_s && (strap_s == STRAP_IO);
   assign nand_straps = test_s && strap_s[STRAP_IRQ7] && !io_straps;
   assign por_rise    = por_s && !por_prev_q;

   always_comb
   begin
      por_prev_d = por_s;
      io_armed_d = io_armed_q;
      nand_d     = nand_q;
      // straps only count while reset is held low
      if (!por_s)
      begin
         io_armed_d = io_straps;
      end
      // nand mode needs test and irq7 held the whole time
      if (!por_s)
      begin
         nand_d = nand_straps && ctrl_q[CTRL_NAND_EN];
      end
      else if (!(test_s && strap_s[STRAP_IRQ7]))
      begin
         nand_d = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         por_prev_q <= 1'b1; // pin idle level: no false rise after reset
         io_armed_q <= 1'b0;
         nand_q     <= 1'b0;
      end
      else
      begin
         por_prev_q <= por_prev_d;
         io_armed_q <= io_armed_d;
         nand_q     <= nand_d;
      end
   end

   // ======================================
   // step sequencer
   seq_state_t state_q;
   seq_state_t state_d;
   logic       ovr_en_q;
   logic       ovr_en_d;
   logic       ovr_oe_q;
   logic       ovr_oe_d;
   logic       ovr_lvl_q;
   logic       ovr_lvl_d;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            // start on the reset release edge [RL2]
            if (por_rise && io_armed_q && ctrl_q[CTRL_IO_EN])
            begin
               state_d = ST_S1;
            end
         end
         ST_S1: state_d = ST_S2; // one step per clock [RL3]
         ST_S2: state_d = ST_S3;
         ST_S3: state_d = ST_S4;
         ST_S4: state_d = ST_S5;
         ST_S5: state_d = ST_S6;
         ST_S6: state_d = ST_S7;
         ST_S7: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
      // pattern table lookup for the coming step [RL4]
      ovr_en_d  = (state_d != ST_IDLE);
      ovr_oe_d  = |(state_d[N_STEP:1] & STEP_OE);
      ovr_lvl_d = |(state_d[N_STEP:1] & STEP_LVL);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_q   <= ST_IDLE;
         ovr_en_q  <= 1'b0;
         ovr_oe_q  <= 1'b0;
         ovr_lvl_q <= 1'b0;
      end
      else
      begin
         state_q   <= state_d;
         ovr_en_q  <= ovr_en_d;
         ovr_oe_q  <= ovr_oe_d;
         ovr_lvl_q <= ovr_lvl_d;
      end
   end

   // ======================================
   // pads
   pad_override u_pads (
      .func_out (func_out),
      .func_oe  (func_oe),
      .ovr_en   (ovr_en_q),
      .ovr_oe   (ovr_oe_q),
      .ovr_lvl  (ovr_lvl_q),
      .pad_out  (pad_out),
      .pad_oe   (pad_oe)
   );

   // pull-ups stay on so floating isa pads read high [RL7]
   assign pad_pullup_en = PULL_MASK;

   // dot clock is timing critical: never touched by the test [RL6]
   assign dot_clock_out = dot_clock_src;

   // ======================================
   // nand chain and suspend pin
   logic [N_NAND-1:0] chain;
   logic              suspend_request_out_n_q;
   logic              suspend_request_out_n_d;
   logic              suspend_request_out_n_oe_q;
   logic              suspend_request_out_n_oe_d;

   genvar g;
   generate
      for (g = 0; g < N_NAND; g++)
      begin : g_chain
         if (g == 0)
         begin : g_head
            assign chain[g] = ~nand_s[g];
         end
         else
         begin : g_link
            assign chain[g] = ~(chain[g-1] & nand_s[g]);
         end
      end
   endgenerate

   always_comb
   begin
      suspend_request_out_n_d    = func_suspend_n;
      suspend_request_out_n_oe_d = 1'b1;
      if (nand_q)
      begin
         suspend_request_out_n_d = chain[N_NAND-1]; // [RL8]
      end
      else if (ovr_en_d)
      begin
         suspend_request_out_n_d    = ovr_lvl_d; // suspend pin joins the pattern [RL5]
         suspend_request_out_n_oe_d = ovr_oe_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         suspend_request_out_n_q    <= 1'b1;
         suspend_request_out_n_oe_q <= 1'b1;
      end
      else
      begin
         suspend_request_out_n_q    <= suspend_request_out_n_d;
         suspend_request_out_n_oe_q <= suspend_request_out_n_oe_d;
      end
   end

   assign suspend_request_out_n = suspend_request_out_n_q;
   assign suspend_oe            = suspend_request_out_n_oe_q;

   // ======================================
   // wishbone slave, one wait state, unmapped reads zero
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;

   always_comb
   begin
      ctrl_d = ctrl_q;
      ack_d  = wb_req;
      rdat_d = 32'h0000_0000;
      if (wb_req && wb_adr_i == ADR_CTRL)
      begin
         rdat_d[1:0] = ctrl_q;
         if (wb_we_i && wb_sel_i[0])
         begin
            ctrl_d = wb_dat_i[1:0];
         end
      end
      else if (wb_req && wb_adr_i == ADR_STATUS)
      begin
         rdat_d[7:0]  = state_q;
         rdat_d[STAT_NAND]  = nand_q;
         rdat_d[STAT_ARMED] = io_armed_q;
         rdat_d[STAT_POR]   = por_s;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_q <= CTRL_RESET;
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ======================================
   // checks
   logic [N_NAND-1:0] nand_low;
   logic              thermo;
   assign nand_low = ~nand_s;
   assign thermo   = ((nand_low & (nand_low + 1'b1)) == '0);

   sequence walk_s;
      (state_q == ST_S2) ##1 (state_q == ST_S3) ##1 (state_q == ST_S4)
      ##1 (state_q == ST_S5) ##1 (state_q == ST_S6) ##1 (state_q == ST_S7)
      ##1 (state_q == ST_IDLE);
   endsequence

   start_edge_a: assert property (@(posedge clk) disable iff (srst) // [RL2]
      state_q == ST_IDLE && por_rise && io_armed_q && ctrl_q[CTRL_IO_EN]
      |=> state_q == ST_S1 && ovr_en_q)
      else $error("test did not start at reset release");

   step_walk_a: assert property (@(posedge clk) disable iff (srst) // [RL3]
      state_q == ST_S1 |=> walk_s)
      else $error("pattern did not advance one step per clock");

   high_step_a: assert property (@(posedge clk) disable iff (srst) // [RL4]
      $past(state_q == ST_S1) && state_q == ST_S2
      |-> pad_oe == '1 && pad_out == '1)
      else $error("step 2 pads not driven high");

   low_step_a: assert property (@(posedge clk) disable iff (srst) // [RL4]
      (state_q == ST_S3 || state_q == ST_S5) |-> pad_oe == '1 && pad_out == '0)
      else $error("low step pads not driven low");

   float_step_a: assert property (@(posedge clk) disable iff (srst) // [RL10]
      (state_q == ST_S1 || state_q == ST_S4 || state_q == ST_S7)
      |-> pad_oe == '0 && !suspend_oe)
      else $error("float step still drives");

   release_pads_a: assert property (@(posedge clk) disable iff (srst) // [RL4]
      state_q == ST_S7 |=> !ovr_en_q && pad_oe == func_oe)
      else $error("pads not handed back after step 7");

   pullup_hold_a: assert property (@(posedge clk) disable iff (srst) // [RL7]
      ovr_en_q |-> (pad_pullup_en & PULL_MASK) == PULL_MASK)
      else $error("isa pull-up dropped during test");

   nand_toggle_a: assert property (@(posedge clk) disable iff (srst) // [RL8]
      nand_q && $past(nand_q) && thermo && $past(thermo)
      && $countones(nand_s ^ $past(nand_s)) == 1
      |=> suspend_request_out_n != $past(suspend_request_out_n))
      else $error("nand output did not toggle");

   suspend_request_out_n_high_a: assert property (@(posedge clk) disable iff (srst) // [RL5]
      !nand_q && state_q == ST_S6 |-> suspend_request_out_n && suspend_oe)
      else $error("suspend pin missed the high step");
endmodule

/* File: dv/pin_tester.sv */
/*
 pin_tester: behavioural board tester on the strap and chain pins.
 assumes the bench calls its tasks from one process only.
*/
module pin_tester
   import pin_test_pkg::*;
(
   input  wire logic                        clk,
   output logic                             por_n,
   output logic                             test_pin,
   output logic [pin_test_pkg::N_STRAP-1:0] irq_strap,
   output logic [pin_test_pkg::N_NAND-1:0]  nand_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      por_n = 1'b1;
      test_pin = 1'b0;
      irq_strap = 5'h00;
      nand_in = 8'hff;
   end

   // ==========================================
   // straps stay put for the whole low phase of por
   task automatic strap_por(input logic t, input logic [N_STRAP-1:0] s);
      @(posedge clk);
      por_n <= 1'b0;
      test_pin <= t;
      irq_strap <= s;
      repeat (6) @(posedge clk);
      por_n <= 1'b1;
   endtask

   // one chain input changes at a time
   task automatic chain_set(input logic [N_NAND-1:0] v);
      @(posedge clk);
      nand_in <= v;
   endtask
endmodule

/* File: dv/io_pin_test_sequencer_tb.sv */
/*
 io_pin_test_sequencer_tb: self-checking bench for the pin test block.
 assumes the tester model drives straps, por and chain pins.
*/
module io_pin_test_sequencer_tb
   import pin_test_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, srst, por_n, test_pin, dot_clock_src, dot_clock_out;
   logic        func_suspend_n, suspend_request_out_n, suspend_oe;
   logic [4:0]  irq_strap;
   logic [7:0]  nand_in;
   logic [15:0] func_out, func_oe, pad_out, pad_oe, pad_pullup_en;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   int          num_errors, samples_checked;
   // step table: bit 0 is clock 1
   localparam logic [6:0] OE_EXP = 7'h36;
   localparam logic [6:0] LV_EXP = 7'h22;

   io_pin_test_sequencer dut (
      .clk                   (clk),
      .srst                  (srst),
      .por_n                 (por_n),
      .test_pin              (test_pin),
      .irq_strap             (irq_strap),
      .nand_in               (nand_in),
      .dot_clock_src         (dot_clock_src),
      .dot_clock_out         (dot_clock_out),
      .func_out              (func_out),
      .func_oe               (func_oe),
      .func_suspend_n        (func_suspend_n),
      .pad_out               (pad_out),
      .pad_oe                (pad_oe),
      .pad_pullup_en         (pad_pullup_en),
      .suspend_request_out_n (suspend_request_out_n),
      .suspend_oe            (suspend_oe),
      .wb_cyc_i              (wb_cyc_i),
      .wb_stb_i              (wb_stb_i),
      .wb_we_i               (wb_we_i),
      .wb_adr_i              (wb_adr_i),
      .wb_sel_i              (wb_sel_i),
      .wb_dat_i              (wb_dat_i),
      .wb_dat_o              (wb_dat_o),
      .wb_ack_o              (wb_ack_o)
   );
   pin_tester tester (.clk(clk), .por_n(por_n), .test_pin(test_pin),
                      .irq_strap(irq_strap), .nand_in(nand_in));

   always #20 clk = ~clk;
   always @(posedge clk) dot_clock_src <= ~dot_clock_src;

   // ==========================================
   // reporting
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================
   // classic wishbone single cycle, bounded wait for ack
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
                     input logic [3:0] sel, output logic [31:0] q);
      int n;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      wb_sel_i <= sel;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20)
      begin
         num_errors++;
         summarize();
      end
   endtask

   function automatic logic chain(input logic [7:0] v);
      logic s;
      s = ~v[0];
      for (int i = 1; i < 8; i++)
         s = ~(s & v[i]);
      return s;
   endfunction

   // ==========================================
   // scenarios
   task automatic reg_scn;
      logic [31:0] q;
      wb(1'b0, ADR_CTRL, 32'h0, 4'hf, q);
      check(q, 32'h3);
      wb(1'b1, ADR_CTRL, 32'h0, 4'he, q);
      wb(1'b0, ADR_CTRL, 32'h0, 4'hf, q);
      check(q, 32'h3);
      wb(1'b1, 4'h8, 32'hffff_ffff, 4'hf, q);
      wb(1'b0, 4'h8, 32'h0, 4'hf, q);
      check(q, 32'h0);
      wb(1'b0, ADR_STATUS, 32'h0, 4'hf, q);
      check(q[7:0], 8'h01);
      check(pad_pullup_en, 16'h00ff);
   endtask

   task automatic io_scn;
      int n;
      tester.strap_por(1'b1, 5'h16);
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (pad_oe !== 16'h0000 && n < 12);
      check(n, 3);
      if (n >= 12)
      begin
         summarize();
      end
      for (int k = 0; k < 7; k++)
      begin
         if (k > 0)
         begin
            @(posedge clk);
            #1;
         end
         check(pad_oe, {16{OE_EXP[k]}});
         check(suspend_oe, OE_EXP[k]);
         check(dot_clock_out, dot_clock_src);
         check(pad_pullup_en, 16'h00ff);
         if (OE_EXP[k])
         begin
            check(pad_out, {16{LV_EXP[k]}});
            check(suspend_request_out_n, LV_EXP[k]);
         end
      end
      @(posedge clk);
      #1;
      check(pad_oe, func_oe);
      check(pad_out, func_out);
      check(suspend_request_out_n, func_suspend_n);
      check(suspend_oe, 1'b1);
   endtask

   // no test may start: pads stay with the functional side
   task automatic refuse(input logic t, input logic [4:0] s);
      tester.strap_por(t, s);
      repeat (12)
      begin
         @(posedge clk);
         #1;
         check(pad_oe, func_oe);
      end
   endtask

   task automatic nand_scn;
      logic [31:0] q;
      logic [7:0]  v;
      logic        last;
      tester.chain_set(8'hff);
      tester.strap_por(1'b1, 5'h10);
      repeat (5) @(posedge clk);
      wb(1'b0, ADR_STATUS, 32'h0, 4'hf, q);
      check(q[8], 1'b1);
      v = 8'hff;
      for (int i = 0; i <= N_NAND; i++)
      begin
         if (i > 0)
         begin
            v[i-1] = 1'b0;
            tester.chain_set(v);
         end
         repeat (5) @(posedge clk);
         #1;
         check(suspend_request_out_n, chain(v));
         check(suspend_oe, 1'b1);
         if (i > 0)
         begin
            check(suspend_request_out_n, !last);
         end
         last = suspend_request_out_n;
      end
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      logic [31:0] q;
      clk = 1'b0;
      srst = 1'b1;
      dot_clock_src = 1'b0;
      func_out = 16'h5a5a;
      func_oe = 16'hc3a5;
      func_suspend_n = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      num_errors = 0;
      samples_checked = 0;
      repeat (9) @(posedge clk);
      #1;
      check(pad_oe, func_oe);
      check(suspend_request_out_n, 1'b1);
      @(posedge clk);
      srst <= 1'b0;
      reg_scn();
      io_scn();
      refuse(1'b1, 5'h06);
      refuse(1'b0, 5'h16);
      wb(1'b1, ADR_CTRL, 32'h2, 4'h1, q);
      refuse(1'b1, 5'h16);
      wb(1'b1, ADR_CTRL, 32'h3, 4'h1, q);
      io_scn();
      nand_scn();
      summarize();
   end
endmodule
